// *** rtl/poc_pkg.sv ***
// Contract
// - Config bits 7:5 pick search target; codes 2..7 give 3,7,15,31,63,127.
// - Codes 0 and 1 give targets 0 and 1; field resets to code 2.
// - Compare a ten-bit target of target times four; two low bits ignored.
// - Target acts as mask of ADC bits ignored when testing for zero.
// - Auto adjust bit set and zero reading: decrement offset trim, flag step.
// - With averaging on, result updates only at the end of each window.
// - Config bits 2:0: zero disables averaging, else window of two to the code.
// - Status bit 2 flags an offset step; clears when status is read; resets to zero.
// - Status bit 0 set when calibration ends; host clears by writing one.
// - Interrupt requested while calibration done and its enable are both set.
// - Interrupt enable bit 3 enables calibration interrupt; resets to zero.
// - Kickoff bit starts calibration; result goes to trim in the same cycle the done flag sets.
package poc_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFFSET_TRIM_ADDR = 8'hc0;
  localparam logic [7:0] KICKOFF_ADDR = 8'hd7;
  localparam logic [7:0] CONFIG_ADDR = 8'hd9;
  localparam logic [7:0] STATUS_ADDR = 8'hdc;
  localparam logic [7:0] INT_ENABLE_ADDR = 8'hdd;
  localparam logic [7:0] RESULT_LO_ADDR = 8'h9c;
  localparam logic [7:0] RESULT_HI_ADDR = 8'h9d;
  localparam logic [6:0] DEVICE_ADDR = 7'h29;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int TARGET_LSB = 5;
  localparam int AUTO_ADJ_BIT = 3;
  localparam int AVG_LSB = 0;
  localparam int STEPPED_BIT = 2;
  localparam int DONE_BIT = 0;
  localparam int CIEN_BIT = 3;
  localparam int KICK_BIT = 0;
  // ---------------------------------------------------------------
  // Reset values and masks
  // ---------------------------------------------------------------
  localparam logic [7:0] CONFIG_RESET = 8'h50;
  localparam logic [2:0] TARGET_RESET_CODE = 3'h2;
  localparam logic [7:0] INT_ENABLE_RESET = 8'h00;
  localparam logic [7:0] INT_ENABLE_MASK = 8'h6c;
  localparam logic [7:0] KICKOFF_RESET = 8'h00;
  localparam logic [7:0] KICKOFF_MASK = 8'h21;
  localparam logic [7:0] TRIM_RESET = 8'h00;
  localparam logic [7:0] TRIM_FIRST_TRIAL = 8'h80;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b000,
    BUS_ADDR = 3'b001,
    BUS_PTR = 3'b010,
    BUS_WRITE = 3'b011,
    BUS_READ = 3'b100
  } poc_bus_st_t;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_MEASURE = 2'b01,
    CAL_WAIT = 2'b10
  } poc_cal_st_t;
endpackage

// *** rtl/poc_target_mask.sv ***
`timescale 1ns/1ps
module poc_target_mask (
  input wire logic [2:0] code,
  input wire logic [9:0] sample,
  output logic [6:0] target,
  output logic is_zero
);
  import poc_pkg::*;

  genvar i;
  generate
    for (i = 0; i < 7; i++) begin : g_bit
      // Codes 0 and 1 pass straight through, higher codes form a run of ones
      assign target[i] = (code >= 3'h2) ? (3'(i) < code) : ((i == 0) && code[0]);
    end
  endgenerate

  // Two low bits are always ignored, so the target acts at four times its value
  wire logic [9:0] keep_mask = ~{1'b0, target, 2'b11};
  assign is_zero = (sample & keep_mask) == 10'h000;
endmodule // poc_target_mask

// *** rtl/poc_window_avg.sv ***
`timescale 1ns/1ps
module poc_window_avg (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [2:0] avg_code,
  input wire logic sample_valid,
  input wire logic [9:0] sample,
  output logic result_valid,
  output logic [9:0] result
);
  import poc_pkg::*;

  logic [16:0] acc_reg;
  logic [7:0] count_reg;

  wire logic [16:0] acc_sum = acc_reg + 17'(sample);
  wire logic [7:0] window = 8'h01 << avg_code;
  wire logic [7:0] count_inc = count_reg + 8'h01;
  // Greater-or-equal closes a window early if the code shrinks mid-window
  wire logic window_end = sample_valid && (avg_code == 3'h0 || count_inc >= window);
  wire logic [16:0] acc_mean = acc_sum >> avg_code;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      acc_reg <= 17'h00000;
      count_reg <= 8'h00;
      result_valid <= 1'b0;
      result <= 10'h000;
    end else if (ce) begin
      result_valid <= window_end;
      if (window_end) begin
        acc_reg <= 17'h00000;
        count_reg <= 8'h00;
        result <= acc_mean[9:0];
      end else if (sample_valid) begin
        acc_reg <= acc_sum;
        count_reg <= count_inc;
      end
    end
  end

  a_avg_bypass: assert property (@(posedge ref_clk) disable iff (!nrst || !ce)
    (ce && sample_valid && avg_code == 3'h0) |=> (result_valid && result == $past(sample)))
    else $error("bypass did not pass the sample through");
  a_avg_hold: assert property (@(posedge ref_clk) disable iff (!nrst || !ce)
    (ce && avg_code != 3'h0 && count_inc < window) |=> !result_valid)
    else $error("result updated before window end");
endmodule // poc_window_avg

// *** rtl/poc_calib_top.sv ***
`timescale 1ns/1ps
module poc_calib_top (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic int_out,
  output logic int_oe_n,
  input wire logic meas_valid,
  input wire logic [9:0] meas_data,
  output logic meas_req,
  output logic [9:0] result_value,
  output logic [7:0] offset_trim
);
  import poc_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers and filters
  // ---------------------------------------------------------------
  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  logic scl_reg;
  logic sda_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else if (ce) begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
      // A level counts only once the second and third stages agree
      if (scl_sync_reg[1] == scl_sync_reg[2]) begin
        scl_reg <= scl_sync_reg[2];
      end
      if (sda_sync_reg[1] == sda_sync_reg[2]) begin
        sda_reg <= sda_sync_reg[2];
      end
      scl_prev_reg <= scl_reg;
      sda_prev_reg <= sda_reg;
    end
  end

  // ---------------------------------------------------------------
  // Serial slave
  // ---------------------------------------------------------------
  poc_bus_st_t bus_st_reg;
  poc_bus_st_t bus_st_next;
  logic [3:0] bit_cnt_reg;
  logic [3:0] bit_cnt_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [7:0] ptr_reg;
  logic [7:0] ptr_next;
  logic [7:0] tx_reg;
  logic [7:0] tx_next;
  logic sda_oe_n_reg;
  logic sda_oe_n_next;
  logic nack_reg;
  logic nack_next;
  logic [7:0] read_data;

  wire logic scl_rise = scl_reg && !scl_prev_reg;
  wire logic scl_fall = !scl_reg && scl_prev_reg;
  wire logic bus_start = scl_reg && scl_prev_reg && sda_prev_reg && !sda_reg;
  wire logic bus_stop = scl_reg && scl_prev_reg && !sda_prev_reg && sda_reg;
  wire logic byte_done = scl_fall && bit_cnt_reg == 4'h8;
  wire logic ack_end = scl_fall && bit_cnt_reg == 4'h9;
  wire logic addr_hit = shift_reg[7:1] == DEVICE_ADDR;
  wire logic host_wr = byte_done && bus_st_reg == BUS_WRITE;
  wire logic read_next = ack_end && bus_st_reg == BUS_READ && !nack_reg;

  always_comb begin
    bus_st_next = bus_st_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    ptr_next = ptr_reg;
    tx_next = tx_reg;
    sda_oe_n_next = sda_oe_n_reg;
    nack_next = nack_reg;
    if (bus_start) begin
      bus_st_next = BUS_ADDR;
      bit_cnt_next = 4'h0;
      sda_oe_n_next = 1'b1;
    end else if (bus_stop) begin
      bus_st_next = BUS_IDLE;
      sda_oe_n_next = 1'b1;
    end else if (bus_st_reg != BUS_IDLE) begin
      if (scl_rise && bit_cnt_reg < 4'h8) begin
        shift_next = {shift_reg[6:0], sda_reg};
        bit_cnt_next = bit_cnt_reg + 4'h1;
      end else if (scl_rise) begin
        bit_cnt_next = 4'h9;
        nack_next = (bus_st_reg == BUS_READ) && sda_reg;
      end else if (byte_done) begin
        sda_oe_n_next = 1'b0;
        case (bus_st_reg)
          BUS_ADDR: begin
            if (!addr_hit) begin
              bus_st_next = BUS_IDLE;
              sda_oe_n_next = 1'b1;
            end else if (shift_reg[0]) begin
              bus_st_next = BUS_READ;
            end else begin
              bus_st_next = BUS_PTR;
            end
          end
          BUS_PTR: begin
            ptr_next = shift_reg;
            bus_st_next = BUS_WRITE;
          end
          BUS_WRITE: ptr_next = ptr_reg + 8'h01;
          default: sda_oe_n_next = 1'b1;
        endcase
      end else if (ack_end) begin
        bit_cnt_next = 4'h0;
        sda_oe_n_next = 1'b1;
        if (bus_st_reg == BUS_READ) begin
          if (nack_reg) begin
            bus_st_next = BUS_IDLE;
          end else begin
            tx_next = read_data;
            sda_oe_n_next = read_data[7];
            ptr_next = ptr_reg + 8'h01;
          end
        end
      end else if (scl_fall && bus_st_reg == BUS_READ && bit_cnt_reg != 4'h0) begin
        tx_next = {tx_reg[6:0], 1'b0};
        sda_oe_n_next = tx_reg[6];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bus_st_reg <= BUS_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      tx_reg <= 8'h00;
      sda_oe_n_reg <= 1'b1;
      nack_reg <= 1'b0;
    end else if (ce) begin
      bus_st_reg <= bus_st_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      ptr_reg <= ptr_next;
      tx_reg <= tx_next;
      sda_oe_n_reg <= sda_oe_n_next;
      nack_reg <= nack_next;
    end
  end

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [7:0] trim_reg;
  logic [7:0] kickoff_reg;
  logic [7:0] config_reg;
  logic [7:0] int_enable_reg;
  logic done_reg;
  logic stepped_reg;
  logic [9:0] result_reg;
  logic int_oe_n_reg;
  logic int_out_reg;
  logic meas_req_reg;

  wire logic wr_trim = host_wr && ptr_reg == OFFSET_TRIM_ADDR;
  wire logic wr_kick = host_wr && ptr_reg == KICKOFF_ADDR;
  wire logic wr_cfg = host_wr && ptr_reg == CONFIG_ADDR;
  wire logic wr_status = host_wr && ptr_reg == STATUS_ADDR;
  wire logic wr_inten = host_wr && ptr_reg == INT_ENABLE_ADDR;
  wire logic rd_status = read_next && ptr_reg == STATUS_ADDR;

  // Only the two flags exist; every other status bit is wired to zero
  wire logic [7:0] status_byte = (8'(done_reg) << DONE_BIT) |
    (8'(stepped_reg) << STEPPED_BIT);

  assign read_data =
    (ptr_reg == OFFSET_TRIM_ADDR) ? trim_reg :
    (ptr_reg == KICKOFF_ADDR) ? kickoff_reg :
    (ptr_reg == CONFIG_ADDR) ? config_reg :
    (ptr_reg == STATUS_ADDR) ? status_byte :
    (ptr_reg == INT_ENABLE_ADDR) ? int_enable_reg :
    (ptr_reg == RESULT_LO_ADDR) ? result_reg[7:0] :
    (ptr_reg == RESULT_HI_ADDR) ? {6'h00, result_reg[9:8]} : 8'h00;

  // ---------------------------------------------------------------
  // Zero detection and averaging
  // ---------------------------------------------------------------
  logic [6:0] cal_target;
  logic meas_zero;
  logic avg_valid;
  logic [9:0] avg_result;
  wire logic [2:0] target_code = config_reg[TARGET_LSB +: 3];
  wire logic [2:0] avg_code = config_reg[AVG_LSB +: 3];

  poc_target_mask u_target (
    .code(target_code),
    .sample(meas_data),
    .target(cal_target),
    .is_zero(meas_zero)
  );

  // ---------------------------------------------------------------
  // Offset calibration by binary search
  // ---------------------------------------------------------------
  poc_cal_st_t cal_st_reg;
  poc_cal_st_t cal_st_next;
  logic [2:0] cal_bit_reg;
  logic [2:0] cal_bit_next;

  wire logic kick_on = kickoff_reg[KICK_BIT];
  wire logic cal_idle = cal_st_reg == CAL_IDLE;
  wire logic cal_start = cal_idle && kick_on;
  wire logic [7:0] cal_onehot = 8'h01 << cal_bit_reg;
  // A zero reading means the trial offset overshot, so the bit is dropped
  wire logic [7:0] cal_kept = meas_zero ? (trim_reg & ~cal_onehot) : trim_reg;
  wire logic cal_sample = cal_st_reg == CAL_WAIT && meas_valid && kick_on;
  wire logic cal_finish = cal_sample && cal_bit_reg == 3'h0;
  wire logic [7:0] cal_trial = cal_finish ? cal_kept : (cal_kept | (cal_onehot >> 1));

  always_comb begin
    cal_st_next = cal_st_reg;
    cal_bit_next = cal_bit_reg;
    case (cal_st_reg)
      CAL_IDLE: begin
        if (kick_on) begin
          cal_st_next = CAL_MEASURE;
          cal_bit_next = 3'h7;
        end
      end
      CAL_MEASURE: cal_st_next = kick_on ? CAL_WAIT : CAL_IDLE;
      CAL_WAIT: begin
        if (!kick_on || cal_finish) begin
          cal_st_next = CAL_IDLE;
        end else if (meas_valid) begin
          cal_st_next = CAL_MEASURE;
          cal_bit_next = cal_bit_reg - 3'h1;
        end
      end
      default: cal_st_next = CAL_IDLE;
    endcase
  end

  // Auto adjust stays out of the way while a calibration owns the trim
  wire logic auto_on = config_reg[AUTO_ADJ_BIT];
  wire logic auto_step = auto_on && meas_valid && meas_zero && cal_idle && !kick_on &&
    trim_reg != 8'h00 && !wr_trim;

  wire logic [7:0] trim_next = wr_trim ? shift_reg :
    cal_start ? TRIM_FIRST_TRIAL :
    cal_sample ? cal_trial :
    auto_step ? trim_reg - 8'h01 : trim_reg;
  wire logic [7:0] kick_next = wr_kick ? (shift_reg & KICKOFF_MASK) :
    cal_finish ? (kickoff_reg & ~KICKOFF_MASK) : kickoff_reg;
  // Hardware sets beat software clears arriving in the same cycle
  wire logic done_next = cal_finish ||
    (done_reg && !(wr_status && shift_reg[DONE_BIT]));
  wire logic stepped_next = auto_step || (stepped_reg && !rd_status);
  wire logic irq_cause = done_reg && int_enable_reg[CIEN_BIT];

  poc_window_avg u_avg (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .ce(ce),
    .avg_code(avg_code),
    .sample_valid(meas_valid && cal_idle && !kick_on),
    .sample(meas_data),
    .result_valid(avg_valid),
    .result(avg_result)
  );

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cal_st_reg <= CAL_IDLE;
      cal_bit_reg <= 3'h7;
      meas_req_reg <= 1'b0;
      trim_reg <= TRIM_RESET;
      kickoff_reg <= KICKOFF_RESET;
    end else if (ce) begin
      cal_st_reg <= cal_st_next;
      cal_bit_reg <= cal_bit_next;
      meas_req_reg <= cal_st_reg == CAL_MEASURE && kick_on;
      trim_reg <= trim_next;
      kickoff_reg <= kick_next;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      config_reg <= CONFIG_RESET;
      int_enable_reg <= INT_ENABLE_RESET;
      done_reg <= 1'b0;
      stepped_reg <= 1'b0;
      result_reg <= 10'h000;
      int_oe_n_reg <= 1'b1;
      int_out_reg <= 1'b0;
    end else if (ce) begin
      if (wr_cfg) begin
        config_reg <= shift_reg;
      end
      if (wr_inten) begin
        int_enable_reg <= shift_reg & INT_ENABLE_MASK;
      end
      done_reg <= done_next;
      stepped_reg <= stepped_next;
      if (avg_valid) begin
        result_reg <= avg_result;
      end
      int_oe_n_reg <= !irq_cause;
      int_out_reg <= 1'b0;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_n = sda_oe_n_reg;
  assign int_out = int_out_reg;
  assign int_oe_n = int_oe_n_reg;
  assign meas_req = meas_req_reg;
  assign result_value = result_reg;
  assign offset_trim = trim_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_target_high: assert property (@(posedge ref_clk) disable iff (!nrst)
    (target_code == 3'h6) |-> (cal_target == 7'd63))
    else $error("code 6 did not select target 63");
  a_target_low: assert property (@(posedge ref_clk) disable iff (!nrst)
    (target_code < 3'h2) |-> (cal_target == {4'h0, target_code}))
    else $error("low target code not passed through");
  a_target_reset: assert property (@(posedge ref_clk)
    $rose(nrst) |-> (target_code == TARGET_RESET_CODE && !int_enable_reg[CIEN_BIT]))
    else $error("target code or interrupt enable reset wrong");
  a_zero_mask: assert property (@(posedge ref_clk) disable iff (!nrst)
    (meas_data[9:2] <= {1'b0, cal_target}) |-> meas_zero)
    else $error("value inside the mask not seen as zero");
  a_zero_above: assert property (@(posedge ref_clk) disable iff (!nrst)
    (meas_data[9:2] > {1'b0, cal_target}) |-> !meas_zero)
    else $error("value above scaled target seen as zero");
  a_auto_step: assert property (@(posedge ref_clk) disable iff (!nrst || !ce)
    (ce && auto_step) |=> (trim_reg == $past(trim_reg) - 8'h01 && stepped_reg))
    else $error("auto adjust did not step the trim");
  a_step_clear: assert property (@(posedge ref_clk) disable iff (!nrst || !ce)
    (ce && rd_status && !auto_step) |=> !stepped_reg)
    else $error("step flag survived a status read");
  a_done_clear: assert property (@(posedge ref_clk) disable iff (!nrst || !ce)
    (ce && wr_status && shift_reg[DONE_BIT] && !cal_finish) |=> !done_reg)
    else $error("write one did not clear done");
  a_cal_finish: assert property (@(posedge ref_clk) disable iff (!nrst || !ce)
    (ce && cal_finish && !wr_kick) |=> (done_reg && !kick_on && cal_idle))
    else $error("calibration end did not set done");
  a_irq_follow: assert property (@(posedge ref_clk) disable iff (!nrst || !ce)
    ce |=> (int_oe_n_reg == !$past(irq_cause)))
    else $error("interrupt pin does not follow done and enable");
  a_status_rsvd: assert property (@(posedge ref_clk) disable iff (!nrst)
    (status_byte[7:3] == 5'h00 && status_byte[1] == 1'b0))
    else $error("reserved status bit not zero");
endmodule // poc_calib_top

// *** verif/poc_host.sv ***
`timescale 1ns/1ps
module poc_host (
  input wire logic ref_clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda
);
  import poc_pkg::*;
  int nacks = 0;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // ----
  // Bus phases
  // ----
  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Phases of 4 and 8 cycles keep both halves of the clock above 5 cycles
  task automatic put_bit(input logic b, output logic got);
    sda <= b;
    hold(4);
    scl <= 1'b1;
    hold(8);
    got = sda_wire;
    scl <= 1'b0;
    hold(4);
  endtask
  task automatic start();
    sda <= 1'b1;
    hold(4);
    scl <= 1'b1;
    hold(8);
    sda <= 1'b0;
    hold(8);
    scl <= 1'b0;
    hold(4);
  endtask
  task automatic stop();
    sda <= 1'b0;
    hold(4);
    scl <= 1'b1;
    hold(8);
    sda <= 1'b1;
    hold(8);
  endtask
  task automatic xfer(input logic [7:0] b, input logic is_rd, output logic [7:0] got);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(b[i], got[i]);
    // A read byte ends in a NACK so the device lets go of the data line
    put_bit(1'b1, a);
    if (!is_rd && a) nacks++;
  endtask
  task automatic wr(input logic [7:0] r, input logic [7:0] d);
    logic [7:0] g;
    start();
    xfer({DEVICE_ADDR, 1'b0}, 1'b0, g);
    xfer(r, 1'b0, g);
    xfer(d, 1'b0, g);
    stop();
  endtask
  task automatic rd(input logic [7:0] r, output logic [7:0] d);
    logic [7:0] g;
    start();
    xfer({DEVICE_ADDR, 1'b0}, 1'b0, g);
    xfer(r, 1'b0, g);
    start();
    xfer({DEVICE_ADDR, 1'b1}, 1'b0, g);
    xfer(8'hff, 1'b1, d);
    stop();
  endtask
endmodule // poc_host

// *** verif/poc_calib_top_bench.sv ***
`timescale 1ns/1ps
module poc_calib_top_bench;
  import poc_pkg::*;
  // ----
  // Wiring
  // ----
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic meas_valid = 1'b0;
  logic [9:0] meas_data = 10'h000;
  logic scl, sda, sda_out, sda_oe_n, int_out, int_oe_n, meas_req;
  logic [9:0] result_value;
  logic [7:0] offset_trim, rd_val;
  int num_errors = 0;
  int checks = 0;
  int reqs = 0;
  // Released lines read high through the pull-ups
  wire sda_wire = sda & (sda_oe_n | sda_out);
  wire int_pin = int_oe_n | int_out;
  poc_host u_host (.ref_clk(ref_clk), .sda_wire(sda_wire), .scl(scl), .sda(sda));
  poc_calib_top uut (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .scl_in(scl),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .int_out(int_out),
    .int_oe_n(int_oe_n), .meas_valid(meas_valid), .meas_data(meas_data),
    .meas_req(meas_req), .result_value(result_value), .offset_trim(offset_trim));
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  // Requests are counted as they pass, since the first one comes while the kickoff write ends
  always @(posedge ref_clk) begin
    if (meas_req === 1'b1) begin
      reqs++;
    end
  end
  // ----
  // Tasks
  // ----
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic summarize();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] r, input logic [7:0] exp);
    u_host.rd(r, rd_val);
    chk({2'b00, rd_val}, {2'b00, exp});
  endtask
  task automatic restart();
    nrst <= 1'b0;
    tick(12);
    nrst <= 1'b1;
    tick(4);
  endtask
  task automatic pulse(input logic [9:0] d, input int n);
    meas_data <= d;
    meas_valid <= 1'b1;
    tick(1);
    meas_valid <= 1'b0;
    tick(n);
  endtask
  task automatic wait_req(input int seen);
    int i;
    for (i = 0; i < 300 && reqs <= seen; i++) tick(1);
    if (i == 300) begin
      num_errors++;
      $display("BAD %0t no measurement request", $time);
      summarize();
    end
  endtask
  initial begin
    tick(90000);
    num_errors++;
    $display("BAD %0t run too long", $time);
    summarize();
  end
  // ----
  // Sequence
  // ----
  initial begin
    int t, thr, d, sum, n, avg;
    void'($urandom(32'h43ab));
    restart();
    rdchk(CONFIG_ADDR, 8'h50);
    rdchk(STATUS_ADDR, 8'h00);
    rdchk(INT_ENABLE_ADDR, 8'h00);
    rdchk(8'h10, 8'h00);
    u_host.wr(STATUS_ADDR, 8'hfe);
    rdchk(STATUS_ADDR, 8'h00);
    u_host.wr(INT_ENABLE_ADDR, 8'hff);
    rdchk(INT_ENABLE_ADDR, 8'h6c);
    chk({2'b00, offset_trim}, 10'h000);
    // Target mask seen through auto adjust: a masked reading steps the trim down
    u_host.wr(OFFSET_TRIM_ADDR, 8'h20);
    for (int c = 0; c < 8; c++) begin
      t = c < 2 ? c : (1 << c) - 1;
      u_host.wr(CONFIG_ADDR, 8'(c << 5) | 8'h18);
      pulse(10'((t << 2) | 3), 3);
      chk({2'b00, offset_trim}, 10'(31 - 2 * c));
      pulse(10'(t << 2), 3);
      chk({2'b00, offset_trim}, 10'(30 - 2 * c));
      pulse(10'((t + 1) << 2), 3);
      chk({2'b00, offset_trim}, 10'(30 - 2 * c));
    end
    for (int c = 0; c < 8; c++) begin
      restart();
      u_host.wr(CONFIG_ADDR, 8'h50 | 8'(c));
      sum = 0;
      n = 0;
      avg = 0;
      for (int k = 0; k < (1 << c) + 2; k++) begin
        d = $urandom_range(1023, 1);
        pulse(10'(d), 3);
        sum += d;
        n++;
        if (n == (1 << c)) begin
          avg = sum >> c;
          sum = 0;
          n = 0;
        end
        chk(result_value, 10'(avg));
      end
    end
    restart();
    u_host.wr(CONFIG_ADDR, 8'h58);
    u_host.wr(OFFSET_TRIM_ADDR, 8'h05);
    pulse(10'h000, 3);
    chk({2'b00, offset_trim}, 10'h004);
    pulse(10'h00b, 3);
    chk({2'b00, offset_trim}, 10'h003);
    rdchk(STATUS_ADDR, 8'h04);
    rdchk(STATUS_ADDR, 8'h00);
    pulse(10'h010, 3);
    chk({2'b00, offset_trim}, 10'h003);
    // A zero reading while the clock enable is low must leave all state alone
    ce <= 1'b0;
    pulse(10'h000, 3);
    ce <= 1'b1;
    chk({2'b00, offset_trim}, 10'h003);
    rdchk(STATUS_ADDR, 8'h00);
    // Reading falls to zero once the trim reaches thr, so the search ends at thr - 1
    for (int k = 0; k < 2; k++) begin
      u_host.wr(INT_ENABLE_ADDR, k == 0 ? 8'h08 : 8'h00);
      thr = $urandom_range(255, 1);
      t = 0;
      for (int b = 7; b >= 0; b--) if ((t | (1 << b)) < thr) t = t | (1 << b);
      u_host.wr(KICKOFF_ADDR, 8'h01);
      for (int s = 0; s < 8; s++) begin
        wait_req(8 * k + s);
        tick($urandom_range(6, 1));
        pulse(offset_trim < thr ? 10'h3ff : 10'h000, 0);
      end
      tick(6);
      chk({2'b00, offset_trim}, 10'(t));
      chk(10'(int_pin), k == 0 ? 10'h000 : 10'h001);
      rdchk(STATUS_ADDR, 8'h01);
      rdchk(KICKOFF_ADDR, 8'h00);
      u_host.wr(STATUS_ADDR, 8'h01);
      rdchk(STATUS_ADDR, 8'h00);
      chk(10'(int_pin), 10'h001);
    end
    chk(10'(u_host.nacks), 10'h000);
    summarize();
  end
endmodule // poc_calib_top_bench
